// ### include/tmr2_defs.vh
/*
 * constants for the 16-bit capture/reload timer: register offsets,
 * control bit positions, reset values and timing.
 * assumes inclusion by bare name from the design files.
 */
`ifndef TMR2_DEFS_VH
`define TMR2_DEFS_VH

// ==========================================
// register byte addresses (word aligned)
`define TMR2_ADDR_W 8
`define TMR2_OFS_CTRL 8'hC8
`define TMR2_OFS_RLD 8'hCC
`define TMR2_OFS_CNT 8'hD0
`define TMR2_OFS_IMASK 8'hD4

// ==========================================
// control register fields
`define TMR2_B_OVF 7
`define TMR2_B_EXF 6
`define TMR2_B_RCLK 5
`define TMR2_B_UART_TX_CLOCK_SELECT 4
`define TMR2_B_EXEN 3
`define TMR2_B_RUN 2
`define TMR2_B_CT 1
`define TMR2_B_CPRL 0
`define TMR2_CTRL_RST 8'h00
`define TMR2_CNT_RST 16'h0000
`define TMR2_MASK_RST 2'h0
`define TMR2_CNT_MAX 16'hFFFF

// ==========================================
// timer mode rate: one increment per two system clocks
`define TMR2_TICK_DIV 1'h1
`define TMR2_UNMAPPED 32'h00000000

`endif

// ### verification/tb.sv
/* tb: self-checking bench for tmr2_top.
 * assumes tmr2_pins and the bound checker. */
`timescale 1ns/10ps
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin errors++; $display("Error %s %h %h", n, e, a); end end
module tb;
  // ==========
  reg clk = 1'h0, arst_n = 1'h0, ce = 1'h1, avs_read = 1'h0, avs_write = 1'h0;
  reg timer1_overflow = 1'h0, cnt_go = 1'h0, trg_go = 1'h0;
  reg [7:0] avs_address = 8'h00;
  reg [31:0] avs_writedata = 32'h0, e, v, w, q[$];
  wire [31:0] avs_readdata;
  wire avs_waitrequest, count_input_pin, ext_trigger_pin, uart_rx_tick, uart_tx_tick, irq;
  integer errors = 0, compares = 0, cyc = 0;
  tmr2_top dut (.*);
  tmr2_pins pins (.*);
  initial forever #50 clk = ~clk;
  // request held until waitrequest is sampled low
  task b(input rw, input [7:0] a, input [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !rw;
    avs_write <= rw;
    do @(posedge clk); while (avs_waitrequest);
    avs_read <= 1'h0;
    avs_write <= 1'h0;
  endtask
  task rd(input [7:0] a, input [31:0] x);
    q.push_back(x);
    b(0, a, x);
  endtask
  // one pin fall, then room for the detector
  task p(input t);
    @(posedge clk);
    trg_go <= t;
    cnt_go <= !t;
    @(posedge clk);
    trg_go <= 1'h0;
    cnt_go <= 1'h0;
    repeat (3) @(posedge clk);
  endtask
  task results;
    if (errors == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // watcher, random timer1 pulses never back to back, hang limit
  always @(posedge clk) begin
    if (avs_read && !avs_waitrequest) begin
      e = q.pop_front();
      `CHK("readdata", e, avs_readdata)
    end
    timer1_overflow <= arst_n && !timer1_overflow && $urandom % 5 == 0;
    cyc <= cyc + 1;
    if (cyc == 9000) begin
      errors++;
      results;
    end
  end
  initial begin
    v = $urandom(15) % 32'h8000;
    w = v + 32'h3;
    repeat (5) @(posedge clk);
    arst_n <= 1'h1;
    for (int i = 0; i < 5; i++) rd(8'hC8 + 8'(i * 4), 32'h0);
    b(1, 8'hD0, v);
    b(1, 8'hC8, 32'h02);
    p(0);
    rd(8'hD0, v);
    b(1, 8'hC8, 32'h06);
    repeat (3) p(0);
    p(1);
    rd(8'hD0, w);
    rd(8'hC8, 32'h06);
    b(1, 8'hD4, 32'h1);
    b(1, 8'hC8, 32'h0F);
    p(1);
    rd(8'hCC, w);
    rd(8'hC8, 32'h4F);
    `CHK("irq", 1'h1, irq)
    b(1, 8'hC8, 32'h0E);
    p(0);
    p(1);
    rd(8'hD0, w);
    b(1, 8'hD0, 32'hFFFF);
    p(0);
    rd(8'hD0, w);
    rd(8'hC8, 32'hCE);
    b(1, 8'hC8, 32'h3F);
    b(1, 8'hD0, 32'hFFFF);
    p(0);
    p(1);
    rd(8'hD0, w);
    rd(8'hC8, 32'h3F);
    `CHK("irq", 1'h0, irq)
    // clock enable low freezes the detector, so this fall is lost
    ce <= 1'h0;
    p(0);
    ce <= 1'h1;
    rd(8'hD0, w);
    b(1, 8'hCC, 32'hFFF0);
    b(1, 8'hD4, 32'h2);
    // start near the top so both timer phases really overflow
    b(1, 8'hD0, 32'hFFF0);
    b(1, 8'hC8, 32'h34);
    repeat (40) @(posedge clk);
    rd(8'hC8, 32'h34);
    b(1, 8'hC8, 32'h04);
    repeat (40) @(posedge clk);
    rd(8'hC8, 32'h84);
    `CHK("irq", 1'h1, irq)
    results;
  end
endmodule

// ### verification/tmr2_pins.sv
/* tmr2_pins: drives the count and trigger pins.
 * assumes go strobes one clock wide, spaced. */
`timescale 1ns/10ps
module tmr2_pins (
  // clock and commands
  input wire clk,
  input wire cnt_go,
  input wire trg_go,
  // pins, idle high
  output reg count_input_pin = 1'h1,
  output reg ext_trigger_pin = 1'h1
);
  // ==========
  // one low sample per go, so exactly one fall
  always @(posedge clk) begin
    count_input_pin <= !cnt_go;
    ext_trigger_pin <= !trg_go;
  end
endmodule

// ### verification/tmr2_props.sv
/* tmr2_props: port checker for tmr2_top.
 * assumes a bind onto tmr2_top, one clock. */
`timescale 1ns/10ps
module tmr2_props (
  // clock, reset
  input wire clk,
  input wire arst_n,
  // bus
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  // uart and interrupt
  input wire timer1_overflow,
  input wire uart_rx_tick,
  input wire uart_tx_tick,
  input wire irq
);
  // ==========
  // shadow of software bits only; hardware sets none of them
  reg [7:0] ctl;
  reg [1:0] msk;
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctl <= 8'h00;
      msk <= 2'h0;
    end else if (avs_write && !avs_waitrequest) begin
      if (avs_address == 8'hC8) ctl <= avs_writedata[7:0];
      if (avs_address == 8'hD4) msk <= avs_writedata[1:0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  property p_one; !avs_waitrequest |=> avs_waitrequest; endproperty
  a_one: assert property (p_one) else $error("long answer");
  property p_ans; $rose(avs_read || avs_write) |=> !avs_waitrequest; endproperty
  a_ans: assert property (p_ans) else $error("no answer");
  property p_hi; avs_readdata[31:16] == 16'h0000; endproperty
  a_hi: assert property (p_hi) else $error("upper bits");
  property p_tx; $past(arst_n) && !$past(ctl[4]) |-> uart_tx_tick == $past(timer1_overflow); endproperty
  a_tx: assert property (p_tx) else $error("tx tick");
  property p_rx; $past(arst_n) && !$past(ctl[5]) |-> uart_rx_tick == $past(timer1_overflow); endproperty
  a_rx: assert property (p_rx) else $error("rx tick");
  property p_irq; $past(msk) == 2'h0 |-> !irq; endproperty
  a_irq: assert property (p_irq) else $error("irq masked");
  property p_txp; uart_tx_tick |=> !uart_tx_tick; endproperty
  a_txp: assert property (p_txp) else $error("tx width");
  property p_rxp; uart_rx_tick |=> !uart_rx_tick; endproperty
  a_rxp: assert property (p_rxp) else $error("rx width");
  cover property (avs_read && !avs_waitrequest);
  cover property (irq);
  cover property (uart_rx_tick && ctl[5]);
endmodule
bind tmr2_top tmr2_props props (.*);

// ### verilog/tmr2_edge.v
/*
 * falling edge detector for one synchronous pin.
 * assumes the pin is already synchronous to clk.
 */
`timescale 1ns/10ps
module tmr2_edge (
  // clock, reset, enable
  input wire clk,
  input wire arst_n,
  input wire ce,
  // pin and edge
  input wire pin,
  output reg fall
);

  reg prev;

  // ==========================================
  // previous sample compared with current one
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prev <= 1'b1;
      fall <= 1'b0;
    end else if (ce) begin
      prev <= pin;
      fall <= prev & ~pin;
    end
  end

endmodule

// ### verilog/tmr2_top.v
/*
 * 16-bit timer/counter with auto-reload and capture, Avalon-MM slave.
 * assumes pins synchronous to clk and a single clock domain.
 */
// The implementer's own choice: the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`include "tmr2_defs.vh"

// Function
// - overflow sets flag unless uart clocks selected
// - trigger capture or reload sets edge flag
// - bit 5 picks uart receive clock
// - bit 4 picks uart transmit clock
// - bit 3 enables trigger pin edges
// - bit 2 runs or holds counter
// - timer mode counts every two clocks
// - counter mode counts count pin falls
// - reload mode reloads on overflow and trigger
// - capture mode captures count on trigger
// - uart clock use forces auto-reload
module tmr2_top (
  // clock, reset, enable
  input wire clk,
  input wire arst_n,
  input wire ce,
  // avalon-mm slave
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  // pins
  input wire count_input_pin,
  input wire ext_trigger_pin,
  // uart baud clocks and interrupt
  input wire timer1_overflow,
  output reg uart_rx_tick,
  output reg uart_tx_tick,
  output reg irq
);

  reg [7:0] ctrl;
  reg [15:0] count;
  reg [15:0] reload_cap;
  reg [1:0] imask;
  reg tick_div;
  reg done;
  wire count_fall;
  wire trig_fall;

  // ==========================================
  // edge detectors for the two pins
  tmr2_edge u_cnt_edge (
    .clk(clk),
    .arst_n(arst_n),
    .ce(ce),
    .pin(count_input_pin),
    .fall(count_fall)
  );

  tmr2_edge u_trg_edge (
    .clk(clk),
    .arst_n(arst_n),
    .ce(ce),
    .pin(ext_trigger_pin),
    .fall(trig_fall)
  );

  // address decode used by both read and write paths
  function hit;
    input [7:0] a;
    input [7:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  // ==========================================
  // counting decisions
  wire run = ctrl[`TMR2_B_RUN];
  wire baud_mode = ctrl[`TMR2_B_RCLK] | ctrl[`TMR2_B_UART_TX_CLOCK_SELECT];
  wire step = run & (ctrl[`TMR2_B_CT] ? count_fall : (tick_div == `TMR2_TICK_DIV));
  wire ovf = step & (count == `TMR2_CNT_MAX);
  // trigger only acts when enabled and uart clocks unused
  wire trig = ctrl[`TMR2_B_EXEN] & ~baud_mode & trig_fall;
  wire capture_mode = ctrl[`TMR2_B_CPRL] & ~baud_mode;
  wire do_reload = ovf | (trig & ~capture_mode);
  wire do_capture = trig & capture_mode;

  // bus strobes taken on the cycle the slave drops waitrequest
  wire acc = (avs_read | avs_write) & ~avs_waitrequest;
  wire wr = avs_write & ~avs_waitrequest;
  wire wr_ctrl = wr & hit(avs_address, `TMR2_OFS_CTRL);
  wire wr_rld = wr & hit(avs_address, `TMR2_OFS_RLD);
  wire wr_cnt = wr & hit(avs_address, `TMR2_OFS_CNT);
  wire wr_mask = wr & hit(avs_address, `TMR2_OFS_IMASK);

  // flag next values: hardware set wins over a software clear
  wire set_ovf = ovf & ~baud_mode;
  wire set_exf = trig;
  wire [7:0] next_ctrl_w = wr_ctrl ? avs_writedata[7:0] : ctrl;
  wire next_ovf = set_ovf | next_ctrl_w[`TMR2_B_OVF];
  wire next_exf = set_exf | next_ctrl_w[`TMR2_B_EXF];

  // ==========================================
  // control register, count and reload/capture
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl <= `TMR2_CTRL_RST;
      count <= `TMR2_CNT_RST;
      reload_cap <= `TMR2_CNT_RST;
      imask <= `TMR2_MASK_RST;
      tick_div <= 1'b0;
    end else if (ce) begin
      ctrl <= {next_ovf, next_exf, next_ctrl_w[5:0]};
      if (wr_mask) begin
        imask <= avs_writedata[1:0];
      end
      // prescaler clears to 0 while run is low so restart is deterministic
      if (run) begin
        tick_div <= ~tick_div;
      end else begin
        tick_div <= 1'b0;
      end
      if (wr_cnt) begin
        count <= avs_writedata[15:0];
      end else if (do_reload) begin
        count <= reload_cap;
      end else if (step) begin
        count <= count + 16'h0001;
      end
      // capture takes priority over a software write in the same cycle
      if (do_capture) begin
        reload_cap <= count;
      end else if (wr_rld) begin
        reload_cap <= avs_writedata[15:0];
      end
    end
  end

  // ==========================================
  // uart baud ticks and interrupt
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      uart_rx_tick <= 1'b0;
      uart_tx_tick <= 1'b0;
      irq <= 1'b0;
    end else if (ce) begin
      uart_rx_tick <= ctrl[`TMR2_B_RCLK] ? ovf : timer1_overflow;
      uart_tx_tick <= ctrl[`TMR2_B_UART_TX_CLOCK_SELECT] ? ovf : timer1_overflow;
      irq <= (next_ovf & imask[1]) | (next_exf & imask[0]);
    end
  end

  // ==========================================
  // bus slave: one wait cycle, then answer
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= `TMR2_UNMAPPED;
      done <= 1'b0;
    end else if (ce) begin
      done <= acc;
      // drop waitrequest for one cycle per request, never back to back
      avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest & ~done);
      if (avs_read & avs_waitrequest) begin
        if (hit(avs_address, `TMR2_OFS_CTRL)) begin
          avs_readdata <= {24'h000000, ctrl};
        end else if (hit(avs_address, `TMR2_OFS_RLD)) begin
          avs_readdata <= {16'h0000, reload_cap};
        end else if (hit(avs_address, `TMR2_OFS_CNT)) begin
          avs_readdata <= {16'h0000, count};
        end else if (hit(avs_address, `TMR2_OFS_IMASK)) begin
          avs_readdata <= {30'h00000000, imask};
        end else begin
          avs_readdata <= `TMR2_UNMAPPED;
        end
      end
    end
  end

endmodule
